/* File: rifc_pkg.sv */
// Package for the reference input configuration register bank
package rifc_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [6:0] OFS_SE1_CFG = 7'h22;
    localparam logic [6:0] OFS_SE2_CFG = 7'h23;
    localparam logic [6:0] OFS_DF1_CFG = 7'h24;
    localparam logic [6:0] OFS_DF2_CFG = 7'h25;
    localparam logic [6:0] OFS_SBY_CFG = 7'h28;
    localparam logic [6:0] OFS_STATE_FORCE = 7'h32;
    localparam logic [7:0] RST_SE_CFG = 8'h00;
    localparam logic [7:0] RST_DF_CFG = 8'h03;
    localparam logic [7:0] RST_STATE_FORCE = 8'h00;
    localparam int BIT_PREDIV = 7;
    localparam int BIT_LOCK8K = 6;
    localparam int BKT_HI = 5;
    localparam int BKT_LO = 4;
    localparam int FREQ_HI = 3;
    localparam int FREQ_LO = 0;
    localparam int FORCE_HI = 2;
    localparam logic [3:0] FREQ_8K = 4'h0;
    localparam logic [3:0] FREQ_T1E1 = 4'h1;
    localparam logic [3:0] FREQ_6M48 = 4'h2;
    localparam logic [3:0] FREQ_155M = 4'h8;
    localparam logic [3:0] FREQ_2K = 4'h9;
    localparam logic [3:0] FREQ_4K = 4'hA;
    localparam logic [2:0] FORCE_AUTO = 3'h0;
    localparam logic [2:0] FORCE_UNUSED = 3'h3;
    localparam int N_INPUTS = 5;
    typedef enum logic [2:0] {
        RIFC_PATH_DIRECT,
        RIFC_PATH_PREDIV,
        RIFC_PATH_LOCK8K
    } rifc_path_e;
endpackage : rifc_pkg

/* File: rifc_regs.sv */
// Reference input frequency configuration and primary loop state force registers
`timescale 1ns/1ns
module rifc_regs (
    input wire logic core_clk, // 20 MHz clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic reg_wr, // Write strobe from serial port
    input wire logic reg_rd, // Read strobe from serial port
    input wire logic [6:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, registered
    input wire logic sonet_or_sdh_rate_select, // High selects 1.544 MHz for code 0001
    output logic [14:0] input_path_sel, // Per input path, 3 bits each
    output logic [9:0] activity_bucket_select, // Per input bucket config, 2 bits each
    output logic [19:0] input_freq_code, // Per input frequency code, 4 bits each
    output logic [4:0] input_freq_valid, // Per input code is a defined value
    output logic [4:0] input_freq_t1, // Per input code 0001 means 1.544 MHz
    output logic [2:0] pll_state_force_code, // Forced state, 000 automatic
    output logic state_forced, // Monitoring may not move the state
    output logic lock8k_code_mismatch // Lock8k set with non-8k code
);
    localparam int NIN = rifc_pkg::N_INPUTS;

    // Configuration copies, one per input
    logic [7:0] cfg_r [NIN];
    logic [7:0] cfg_nxt [NIN];

    // State force field; only the low three bits are stored
    logic [2:0] force_r;
    logic [2:0] force_nxt;

    // Read data holding register
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Shared address decode
    logic [NIN-1:0] cfg_hit;
    logic force_hit;

    // Per input lock option without the 8 kHz code
    logic [NIN-1:0] mismatch;

    // Address of the configuration copy that serves input idx
    function automatic logic [6:0] cfg_addr(input int idx);
        case (idx)
            0: cfg_addr = rifc_pkg::OFS_SE1_CFG;
            1: cfg_addr = rifc_pkg::OFS_SE2_CFG;
            2: cfg_addr = rifc_pkg::OFS_DF1_CFG;
            3: cfg_addr = rifc_pkg::OFS_DF2_CFG;
            default: cfg_addr = rifc_pkg::OFS_SBY_CFG;
        endcase
    endfunction : cfg_addr

    // Single-ended copies come up blank, the others at the 19.44 MHz code
    function automatic logic [7:0] cfg_reset(input int idx);
        cfg_reset = (idx < 2) ? rifc_pkg::RST_SE_CFG : rifc_pkg::RST_DF_CFG;
    endfunction : cfg_reset

    // Codes above 4 kHz are reserved and must not be used by the loop
    function automatic logic freq_defined(input logic [3:0] code);
        freq_defined = (code <= rifc_pkg::FREQ_4K);
    endfunction : freq_defined

    function automatic logic [3:0] freq_field(input logic [7:0] cfg);
        freq_field = cfg[rifc_pkg::FREQ_HI:rifc_pkg::FREQ_LO];
    endfunction : freq_field

    function automatic logic [1:0] bucket_field(input logic [7:0] cfg);
        bucket_field = cfg[rifc_pkg::BKT_HI:rifc_pkg::BKT_LO];
    endfunction : bucket_field

    // The pre-divider wins; the lock bit only counts with it clear
    function automatic rifc_pkg::rifc_path_e path_of(input logic [7:0] cfg);
        if (cfg[rifc_pkg::BIT_PREDIV]) begin
            path_of = rifc_pkg::RIFC_PATH_PREDIV;
        end else if (cfg[rifc_pkg::BIT_LOCK8K]) begin
            path_of = rifc_pkg::RIFC_PATH_LOCK8K;
        end else begin
            path_of = rifc_pkg::RIFC_PATH_DIRECT;
        end
    endfunction : path_of

    // Lock option only matters when the pre-divider is bypassed
    function automatic logic lock_conflict(input logic [7:0] cfg);
        lock_conflict = cfg[rifc_pkg::BIT_LOCK8K]
            && !cfg[rifc_pkg::BIT_PREDIV]
            && (freq_field(cfg) != rifc_pkg::FREQ_8K);
    endfunction : lock_conflict

    genvar g;

    // One decode feeds both the write and the read path
    generate
        for (g = 0; g < NIN; g++) begin : g_hit
            assign cfg_hit[g] = (reg_addr == cfg_addr(g));
        end
    endgenerate

    assign force_hit = (reg_addr == rifc_pkg::OFS_STATE_FORCE);

    // Configuration copies
    always_comb begin
        for (int i = 0; i < NIN; i++) begin
            cfg_nxt[i] = cfg_r[i];
            if (reg_wr && cfg_hit[i]) begin
                cfg_nxt[i] = reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NIN; i++) begin
            if (!rst_b) begin
                cfg_r[i] <= cfg_reset(i);
            end else begin
                cfg_r[i] <= cfg_nxt[i];
            end
        end
    end

    // Upper bits are dropped on write, so they always read back as zero
    always_comb begin
        force_nxt = force_r;
        if (reg_wr && force_hit) begin
            force_nxt = reg_wdata[rifc_pkg::FORCE_HI:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            force_r <= rifc_pkg::RST_STATE_FORCE[rifc_pkg::FORCE_HI:0];
        end else begin
            force_r <= force_nxt;
        end
    end

    // A read in the same cycle as a write returns the old contents
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            // Unmapped addresses read as zero
            rdata_nxt = '0;
            for (int i = 0; i < NIN; i++) begin
                if (cfg_hit[i]) begin
                    rdata_nxt = cfg_r[i];
                end
            end
            if (force_hit) begin
                rdata_nxt = {5'h00, force_r};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // The loop block reads these decoded controls straight from the stored fields
    generate
        for (g = 0; g < NIN; g++) begin : g_in
            rifc_pkg::rifc_path_e path;

            assign path = path_of(cfg_r[g]);

            assign input_path_sel[3*g +: 3] = path;

            assign activity_bucket_select[2*g +: 2] = bucket_field(cfg_r[g]);

            assign input_freq_code[4*g +: 4] = freq_field(cfg_r[g]);

            assign input_freq_valid[g] = freq_defined(freq_field(cfg_r[g]));

            // The rate select only picks between the two telecom rates of code 0001
            assign input_freq_t1[g] = (freq_field(cfg_r[g]) == rifc_pkg::FREQ_T1E1)
                && sonet_or_sdh_rate_select;

            // Flag only; software is trusted to pick the 8 kHz code
            assign mismatch[g] = lock_conflict(cfg_r[g]);
        end
    endgenerate

    assign lock8k_code_mismatch = |mismatch;

    // Unused code 011 is treated as automatic so no undefined state is forced;
    // it is still stored and read back as written
    assign pll_state_force_code = (force_r == rifc_pkg::FORCE_UNUSED) ?
        rifc_pkg::FORCE_AUTO : force_r;

    // Any forced state locks out the monitors' own state changes
    assign state_forced = (pll_state_force_code != rifc_pkg::FORCE_AUTO);

    // Decoded controls only; the loop, pre-dividers and buckets live elsewhere,
    // so a change here takes effect on the cycle after the write edge.
    // Inputs are taken from the same clock as the serial port logic,
    // so no synchroniser stands in front of them.
endmodule : rifc_regs

/* File: rifc_regs_properties.sv */
// Assertions for the input configuration register bank
`timescale 1ns/1ns
module rifc_regs_properties (
    input wire logic core_clk, rst_b, reg_wr, reg_rd, sonet_or_sdh_rate_select,
    input wire logic state_forced, lock8k_code_mismatch,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    input wire logic [14:0] input_path_sel,
    input wire logic [9:0] activity_bucket_select,
    input wire logic [19:0] input_freq_code,
    input wire logic [4:0] input_freq_valid, input_freq_t1,
    input wire logic [2:0] pll_state_force_code
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence wr_se1; reg_wr && reg_addr == 7'h22; endsequence
    sequence wr_force; reg_wr && reg_addr == 7'h32; endsequence
    se1_code_a: assert property (wr_se1 |=>
        input_freq_code[3:0] == $past(reg_wdata[3:0])) else $error("code not stored");
    se1_bucket_a: assert property (wr_se1 |=>
        activity_bucket_select[1:0] == $past(reg_wdata[5:4])) else $error("bucket not stored");
    se1_path_a: assert property (wr_se1 |=> input_path_sel[2:0] ==
        ($past(reg_wdata[7]) ? 3'h1 : $past(reg_wdata[6]) ? 3'h2 : 3'h0)) else $error("path wrong");
    code_valid_a: assert property (input_freq_valid[0] == (input_freq_code[3:0] <= 4'hA))
        else $error("valid wrong");
    t1_rate_a: assert property (input_freq_t1[4] ==
        (input_freq_code[19:16] == 4'h1 && sonet_or_sdh_rate_select)) else $error("rate wrong");
    reset_vals_a: assert property (disable iff (1'b0)
        !rst_b |=> input_freq_code == 20'h33300) else $error("reset value wrong");
    force_code_a: assert property (wr_force |=> pll_state_force_code ==
        ($past(reg_wdata[2:0]) == 3'h3 ? 3'h0 : $past(reg_wdata[2:0]))) else $error("force wrong");
    forced_flag_a: assert property (state_forced == (pll_state_force_code != 3'h0))
        else $error("forced flag wrong");
    force_unused_a: assert property (reg_rd && reg_addr == 7'h32 |=>
        reg_rdata[7:3] == 5'h00) else $error("unused bits set");
endmodule : rifc_regs_properties

/* File: tb_top.sv */
// Self-checking bench for the input configuration register bank
`timescale 1ns/1ns
module tb_top;
    logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, sonet_or_sdh_rate_select = 0;
    logic state_forced, lock8k_code_mismatch;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, w;
    logic [14:0] input_path_sel;
    logic [9:0] activity_bucket_select;
    logic [19:0] input_freq_code;
    logic [4:0] input_freq_valid, input_freq_t1;
    logic [2:0] pll_state_force_code;
    logic [6:0] adr [5] = '{7'h22, 7'h23, 7'h24, 7'h25, 7'h28};
    logic [7:0] rstv [5] = '{8'h00, 8'h00, 8'h03, 8'h03, 8'h03};
    logic [7:0] mdl [5] = '{8'h00, 8'h00, 8'h03, 8'h03, 8'h03};
    int num_errors = 0, comparisons = 0, k;
    rifc_regs i_dut (.*);
    initial forever #25 core_clk = ~core_clk;
    function logic [2:0] path(logic [7:0] v);
        return v[7] ? 3'h1 : v[6] ? 3'h2 : 3'h0;
    endfunction : path
    function logic mm_exp();
        mm_exp = 1'b0;
        for (int j = 0; j < 5; j++) begin
            mm_exp = mm_exp | (mdl[j][6] && !mdl[j][7] && mdl[j][3:0] != 4'h0);
        end
    endfunction : mm_exp
    task chk(string n, logic [19:0] s, e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task acc(logic iw, logic [6:0] a, logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= iw;
        reg_rd <= !iw;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge core_clk);
    endtask : acc
    task results;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    initial begin
        #300000;
        num_errors++;
        results;
    end
    initial begin
        void'($urandom(29));
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            acc(0, i < 5 ? adr[i] : 7'h32, 8'h00);
            chk("reset value", reg_rdata, i < 5 ? rstv[i] : 8'h00);
        end
        chk("lock flag reset", lock8k_code_mismatch, 1'b0);
        for (int n = 0; n < 48; n++) begin
            k = $urandom_range(4);
            w = 8'($urandom);
            if (n % 4 == 0) w[3:0] = 4'h1;
            if (n % 8 == 1) w[7:6] = 2'b01;
            if (n % 16 == 1) w[3:0] = 4'h0;
            @(posedge core_clk);
            sonet_or_sdh_rate_select <= 1'($urandom);
            acc(1, adr[k], w);
            mdl[k] = w;
            chk("lock flag", lock8k_code_mismatch, mm_exp());
            chk("freq code", input_freq_code[4*k+:4], w[3:0]);
            chk("bucket", activity_bucket_select[2*k+:2], w[5:4]);
            chk("path", input_path_sel[3*k+:3], path(w));
            chk("code valid", input_freq_valid[k], w[3:0] <= 4'hA);
            chk("t1 rate", input_freq_t1[k], w[3:0] == 4'h1 && sonet_or_sdh_rate_select);
            acc(0, adr[k], 8'h00);
            chk("readback", reg_rdata, w);
        end
        for (int f = 0; f < 8; f++) begin
            acc(1, 7'h32, {5'h1F, 3'(f)});
            chk("force code", pll_state_force_code, f == 3 ? 0 : f);
            chk("forced", state_forced, f != 0 && f != 3);
            acc(0, 7'h32, 8'h00);
            chk("force read", reg_rdata, f);
        end
        acc(1, 7'h26, 8'h5A);
        acc(0, 7'h26, 8'h00);
        chk("unmapped", reg_rdata, 8'h00);
        results;
    end
endmodule : tb_top
bind rifc_regs rifc_regs_properties i_chk (.*);
